// *** mirf_host.sv ***
// Host model that owns the register port of the router
`timescale 1ns/1ps
module mirf_host
  import mirf_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Register port
  output logic [MIRF_AW-1:0] o_addr,
  output logic [MIRF_DW-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [MIRF_DW-1:0] i_rdata
);
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Idle bus shows the inverse of the last access so stale values never pass
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // Sources are read once per interrupt, not polled, as a summary or source read releases latched flags
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule // mirf_host

// *** mirf_pkg.sv ***
// Constants, register map and state type of the motion interrupt router with free-fall detector
package mirf_pkg;

  localparam int MIRF_AW = 4;
  localparam int MIRF_DW = 8;
  localparam int MIRF_XW = 16;
  localparam int MIRF_CW = 6;

  // Register offsets
  localparam logic [3:0] MIRF_OFS_P1_DATA = 4'h0;
  localparam logic [3:0] MIRF_OFS_P1_MOTION = 4'h1;
  localparam logic [3:0] MIRF_OFS_P2_DATA = 4'h2;
  localparam logic [3:0] MIRF_OFS_P2_MOTION = 4'h3;
  localparam logic [3:0] MIRF_OFS_CTRL = 4'h4;
  localparam logic [3:0] MIRF_OFS_FALL_CFG = 4'h5;
  localparam logic [3:0] MIRF_OFS_WAKE_DUR = 4'h6;
  localparam logic [3:0] MIRF_OFS_SUMMARY = 4'h7;
  localparam logic [3:0] MIRF_OFS_WAKE_FALL_SRC = 4'h8;
  localparam logic [3:0] MIRF_OFS_ORIENT_SRC = 4'h9;

  // Reset values
  localparam logic [7:0] MIRF_RST_ROUTE = 8'h00;
  localparam logic [7:0] MIRF_RST_CTRL = 8'h00;
  localparam logic [7:0] MIRF_RST_CFG = 8'h00;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MIRF_MASK_P1_DATA = 8'hff;
  localparam logic [7:0] MIRF_MASK_MOTION = 8'hb7;
  localparam logic [7:0] MIRF_MASK_P2_DATA = 8'h7f;
  localparam logic [7:0] MIRF_MASK_CTRL = 8'h8f;
  localparam logic [7:0] MIRF_MASK_WAKE_DUR = 8'h80;

  // Control register fields
  localparam int MIRF_CTL_LATCH = 0;
  localparam int MIRF_CTL_CLR_READ = 1;
  localparam int MIRF_CTL_MERGE = 2;
  localparam int MIRF_CTL_POL_LOW = 3;
  localparam int MIRF_CTL_BASIC_EN = 7;

  // Motion routing register fields
  localparam int MIRF_MR_ACT = 7;
  localparam int MIRF_MR_WAKE = 5;
  localparam int MIRF_MR_FALL = 4;
  localparam int MIRF_MR_ORIENT = 2;
  localparam int MIRF_MR_EMB = 1;
  localparam int MIRF_MR_LOW = 0;

  // Basic event index, also the bit in the summary register
  localparam int MIRF_NEV = 4;
  localparam int MIRF_EV_FALL = 0;
  localparam int MIRF_EV_WAKE = 1;
  localparam int MIRF_EV_ORIENT = 2;
  localparam int MIRF_EV_ACT = 3;

  // Source register fields
  localparam int MIRF_WFS_FALL = 5;
  localparam int MIRF_WFS_ACT = 4;
  localparam int MIRF_WFS_WAKE = 3;
  localparam int MIRF_ORS_FLAG = 6;

  // Free-fall configuration fields
  localparam int MIRF_FC_THR_LSB = 0;
  localparam int MIRF_FC_DUR_LSB = 3;
  localparam int MIRF_WD_DUR_HI = 7;

  // Zone amplitude in mg, the same for every full scale
  function automatic logic [15:0] mirf_fall_thr(input logic [2:0] code);
    logic [15:0] thr;
    thr = 16'h0000;
    unique case (code)
      3'h0: thr = 16'd156;
      3'h1: thr = 16'd219;
      3'h2: thr = 16'd250;
      3'h3: thr = 16'd312;
      3'h4: thr = 16'd344;
      3'h5: thr = 16'd406;
      3'h6: thr = 16'd469;
      3'h7: thr = 16'd500;
    endcase
    return thr;
  endfunction

  typedef struct packed {
    logic [7:0] p1_data;
    logic [7:0] p1_motion;
    logic [7:0] p2_data;
    logic [7:0] p2_motion;
    logic [7:0] ctrl;
    logic [7:0] fall_cfg;
    logic [7:0] wake_dur;
    logic [MIRF_NEV-1:0] flag;
    logic [MIRF_NEV-1:0] pend_clr;
    logic [MIRF_CW-1:0] fall_cnt;
    logic fall_cond;
    logic pin_a;
    logic pin_b;
    logic [7:0] rdata;
  } mirf_state_t;

endpackage

// *** mirf_router.sv ***
// Interrupt routing, latching and free-fall detection with a plain register port
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps

// Behaviour
// RL1: All four routing registers reset to zero; a set bit routes its event.
// RL2: First data route bits: stamp, batch, full, overrun, level, boot, gyro, accel.
// RL3: First motion route: activity, wake, fall, orient, embedded, hub; b6 b3 zero.
// RL4: Second data route: b7 zero, batch, full, overrun, level, temp, gyro, accel.
// RL5: Second motion route like first, b0 routes timestamp overflow.
// RL6: A pin is the OR of all events routed to it.
// RL7: Summary register gathers orientation, fall, wake and activity flags.
// RL8: Merge bit set ORs everything onto the first pin.
// RL9: Basic motion events only arise while the basic enable bit is set.
// RL10: Latched routed event holds until source read, released at next sample.
// RL11: Latching applies only to events routed to some pin.
// RL12: Host reads sources on interrupt rather than polling them in latch mode.
// RL13: Clear-on-read clears pin and flag at once; otherwise at next sample.
// RL14: Free-fall sets its source flag, reaching pins via fall route and enable.
// RL15: Unlatched free-fall drops as soon as the zone condition ends.
// RL16: Latched routed free-fall holds until wake-fall source or summary read.
// RL17: Three-bit threshold code selects zone amplitude 156 to 500 mg.
// RL18: Minimum duration is a six-bit count of samples across two registers.
// RL19: Free-fall when all three axes lie inside the zone.
// RL20: Polarity bit zero gives active-high pins, one gives active-low.
// RL21: Detection uses accelerometer samples only, needing an active accelerometer.
// RL22: Duration counter steps per inside sample, clears when any axis leaves.
module mirf_router
  import mirf_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [MIRF_AW-1:0] i_addr,
  input wire logic [MIRF_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [MIRF_DW-1:0] o_rdata,
  // Data and queue events, active-high levels
  input wire logic i_stamp_drdy,
  input wire logic i_batch_count,
  input wire logic i_queue_full,
  input wire logic i_queue_overrun,
  input wire logic i_queue_level,
  input wire logic i_boot_done,
  input wire logic i_gyro_ready,
  input wire logic i_accel_ready,
  input wire logic i_temp_ready,
  input wire logic i_embedded,
  input wire logic i_hub_done,
  input wire logic i_stamp_overflow,
  // Basic motion detectors outside this block, active-high levels
  input wire logic i_wake_evt,
  input wire logic i_orient_evt,
  input wire logic i_activity_evt,
  input wire logic [5:0] i_orient_axes,
  // Accelerometer samples in mg
  input wire logic i_accel_active,
  input wire logic i_sample_stb,
  input wire logic signed [MIRF_XW-1:0] i_accel_x,
  input wire logic signed [MIRF_XW-1:0] i_accel_y,
  input wire logic signed [MIRF_XW-1:0] i_accel_z,
  // Interrupt pins
  output logic o_irq_pin_a,
  output logic o_irq_pin_b
);

  mirf_state_t st_ff;
  mirf_state_t nxt_st;

  logic latch_select;
  logic clear_when_read;
  logic merge_pins_select;
  logic pin_polarity_low;
  logic basic_en;
  logic [MIRF_CW-1:0] fall_duration_count;
  logic signed [MIRF_XW-1:0] fall_thr;
  logic in_zone;
  logic [MIRF_CW-1:0] cnt_inc;
  logic [MIRF_NEV-1:0] raw_evt;
  logic [MIRF_NEV-1:0] routed;
  logic [MIRF_NEV-1:0] latched;
  logic [MIRF_NEV-1:0] rd_clr;
  logic [7:0] motion_a;
  logic [7:0] motion_b;
  logic [7:0] data_a;
  logic [7:0] data_b;
  logic sig_a;
  logic sig_b;
  logic [7:0] summary;
  logic [7:0] wake_fall_source;
  logic [7:0] orientation_source;

  assign latch_select = st_ff.ctrl[MIRF_CTL_LATCH];
  assign clear_when_read = st_ff.ctrl[MIRF_CTL_CLR_READ];
  assign merge_pins_select = st_ff.ctrl[MIRF_CTL_MERGE];
  assign pin_polarity_low = st_ff.ctrl[MIRF_CTL_POL_LOW];
  assign basic_en = st_ff.ctrl[MIRF_CTL_BASIC_EN];

  // Bit 5 of the duration lives in the wake duration register
  assign fall_duration_count = {st_ff.wake_dur[MIRF_WD_DUR_HI], st_ff.fall_cfg[7:MIRF_FC_DUR_LSB]}; // see RL18
  assign fall_thr = $signed(mirf_fall_thr(st_ff.fall_cfg[MIRF_FC_THR_LSB +: 3])); // see RL17

  // Strict inside test; a sample exactly on the threshold is outside
  assign in_zone = (i_accel_x < fall_thr) && (i_accel_x > -fall_thr) &&
                   (i_accel_y < fall_thr) && (i_accel_y > -fall_thr) &&
                   (i_accel_z < fall_thr) && (i_accel_z > -fall_thr); // see RL19

  // Saturates so a long fall never wraps back below the duration
  assign cnt_inc = (&st_ff.fall_cnt) ? st_ff.fall_cnt : st_ff.fall_cnt + 6'h01;

  always_comb begin
    raw_evt = '0;
    raw_evt[MIRF_EV_FALL] = st_ff.fall_cond;
    raw_evt[MIRF_EV_WAKE] = i_wake_evt;
    raw_evt[MIRF_EV_ORIENT] = i_orient_evt;
    raw_evt[MIRF_EV_ACT] = i_activity_evt;
    raw_evt = raw_evt & {MIRF_NEV{basic_en}}; // see RL9
  end

  always_comb begin
    routed = '0;
    routed[MIRF_EV_FALL] = st_ff.p1_motion[MIRF_MR_FALL] | st_ff.p2_motion[MIRF_MR_FALL];
    routed[MIRF_EV_WAKE] = st_ff.p1_motion[MIRF_MR_WAKE] | st_ff.p2_motion[MIRF_MR_WAKE];
    routed[MIRF_EV_ORIENT] = st_ff.p1_motion[MIRF_MR_ORIENT] | st_ff.p2_motion[MIRF_MR_ORIENT];
    routed[MIRF_EV_ACT] = st_ff.p1_motion[MIRF_MR_ACT] | st_ff.p2_motion[MIRF_MR_ACT];
  end

  assign latched = routed & {MIRF_NEV{latch_select}}; // see RL11

  // Reads that release latched flags
  always_comb begin
    rd_clr = '0;
    if (i_rd && (i_addr == MIRF_OFS_SUMMARY)) begin
      rd_clr = '1; // see RL10
    end else if (i_rd && (i_addr == MIRF_OFS_WAKE_FALL_SRC)) begin
      rd_clr[MIRF_EV_FALL] = 1'b1; // see RL16
      rd_clr[MIRF_EV_WAKE] = 1'b1;
      rd_clr[MIRF_EV_ACT] = 1'b1;
    end else if (i_rd && (i_addr == MIRF_OFS_ORIENT_SRC)) begin
      rd_clr[MIRF_EV_ORIENT] = 1'b1;
    end
  end

  always_comb begin
    summary = '0;
    summary[MIRF_NEV-1:0] = st_ff.flag; // see RL7
    wake_fall_source = '0;
    wake_fall_source[MIRF_WFS_FALL] = st_ff.flag[MIRF_EV_FALL]; // see RL14
    wake_fall_source[MIRF_WFS_ACT] = st_ff.flag[MIRF_EV_ACT];
    wake_fall_source[MIRF_WFS_WAKE] = st_ff.flag[MIRF_EV_WAKE];
    orientation_source = '0;
    orientation_source[MIRF_ORS_FLAG] = st_ff.flag[MIRF_EV_ORIENT];
    orientation_source[5:0] = i_orient_axes;
  end

  // Pin source vectors follow the routing register bit order
  always_comb begin
    data_a = {i_stamp_drdy, i_batch_count, i_queue_full, i_queue_overrun,
              i_queue_level, i_boot_done, i_gyro_ready, i_accel_ready}; // see RL2
    data_b = {1'b0, i_batch_count, i_queue_full, i_queue_overrun,
              i_queue_level, i_temp_ready, i_gyro_ready, i_accel_ready}; // see RL4
    motion_a = '0;
    motion_a[MIRF_MR_ACT] = st_ff.flag[MIRF_EV_ACT];
    motion_a[MIRF_MR_WAKE] = st_ff.flag[MIRF_EV_WAKE];
    motion_a[MIRF_MR_FALL] = st_ff.flag[MIRF_EV_FALL];
    motion_a[MIRF_MR_ORIENT] = st_ff.flag[MIRF_EV_ORIENT];
    motion_a[MIRF_MR_EMB] = i_embedded;
    motion_a[MIRF_MR_LOW] = i_hub_done; // see RL3
    motion_b = motion_a;
    motion_b[MIRF_MR_LOW] = i_stamp_overflow; // see RL5
  end

  assign sig_a = |(st_ff.p1_data & data_a) | |(st_ff.p1_motion & motion_a); // see RL6
  assign sig_b = |(st_ff.p2_data & data_b) | |(st_ff.p2_motion & motion_b); // see RL6

  always_comb begin
    nxt_st = st_ff;

    // Register writes; reserved bits stay zero
    if (i_wr) begin
      unique case (i_addr)
        MIRF_OFS_P1_DATA: nxt_st.p1_data = i_wdata & MIRF_MASK_P1_DATA; // see RL1
        MIRF_OFS_P1_MOTION: nxt_st.p1_motion = i_wdata & MIRF_MASK_MOTION; // see RL3
        MIRF_OFS_P2_DATA: nxt_st.p2_data = i_wdata & MIRF_MASK_P2_DATA; // see RL4
        MIRF_OFS_P2_MOTION: nxt_st.p2_motion = i_wdata & MIRF_MASK_MOTION; // see RL5
        MIRF_OFS_CTRL: nxt_st.ctrl = i_wdata & MIRF_MASK_CTRL;
        MIRF_OFS_FALL_CFG: nxt_st.fall_cfg = i_wdata;
        MIRF_OFS_WAKE_DUR: nxt_st.wake_dur = i_wdata & MIRF_MASK_WAKE_DUR;
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        MIRF_OFS_P1_DATA: nxt_st.rdata = st_ff.p1_data;
        MIRF_OFS_P1_MOTION: nxt_st.rdata = st_ff.p1_motion;
        MIRF_OFS_P2_DATA: nxt_st.rdata = st_ff.p2_data;
        MIRF_OFS_P2_MOTION: nxt_st.rdata = st_ff.p2_motion;
        MIRF_OFS_CTRL: nxt_st.rdata = st_ff.ctrl;
        MIRF_OFS_FALL_CFG: nxt_st.rdata = st_ff.fall_cfg;
        MIRF_OFS_WAKE_DUR: nxt_st.rdata = st_ff.wake_dur;
        MIRF_OFS_SUMMARY: nxt_st.rdata = summary;
        MIRF_OFS_WAKE_FALL_SRC: nxt_st.rdata = wake_fall_source;
        MIRF_OFS_ORIENT_SRC: nxt_st.rdata = orientation_source;
        default: nxt_st.rdata = '0;
      endcase
    end

    // Free-fall detector runs on accelerometer sample strobes only
    if (!i_accel_active) begin
      nxt_st.fall_cnt = '0; // see RL21
      nxt_st.fall_cond = 1'b0;
    end else if (i_sample_stb) begin
      if (in_zone) begin
        nxt_st.fall_cnt = cnt_inc; // see RL22
        nxt_st.fall_cond = (cnt_inc >= fall_duration_count); // see RL18
      end else begin
        nxt_st.fall_cnt = '0; // see RL22
        nxt_st.fall_cond = 1'b0;
      end
    end

    // Basic event flags
    for (int k = 0; k < MIRF_NEV; k++) begin
      // Dropping the enable also empties held flags, so a stale latch cannot fire later
      if (!latched[k] || !basic_en) begin
        nxt_st.flag[k] = raw_evt[k]; // see RL15
        nxt_st.pend_clr[k] = 1'b0;
      end else if (raw_evt[k]) begin
        // A new event beats a clear arriving in the same cycle
        nxt_st.flag[k] = 1'b1; // see RL10
        nxt_st.pend_clr[k] = 1'b0;
      end else if (st_ff.pend_clr[k] && i_sample_stb) begin
        nxt_st.flag[k] = 1'b0; // see RL13
        nxt_st.pend_clr[k] = 1'b0;
      end else if (rd_clr[k] && st_ff.flag[k]) begin
        if (clear_when_read) begin
          nxt_st.flag[k] = 1'b0; // see RL13
        end else begin
          nxt_st.pend_clr[k] = 1'b1; // see RL16
        end
      end
    end

    // Pins: merge, then polarity
    if (merge_pins_select) begin
      nxt_st.pin_a = (sig_a | sig_b) ^ pin_polarity_low; // see RL8
      nxt_st.pin_b = pin_polarity_low;
    end else begin
      nxt_st.pin_a = sig_a ^ pin_polarity_low; // see RL20
      nxt_st.pin_b = sig_b ^ pin_polarity_low;
    end

    if (i_rst) begin
      nxt_st = '0;
      nxt_st.p1_data = MIRF_RST_ROUTE; // see RL1
      nxt_st.p1_motion = MIRF_RST_ROUTE;
      nxt_st.p2_data = MIRF_RST_ROUTE;
      nxt_st.p2_motion = MIRF_RST_ROUTE;
      nxt_st.ctrl = MIRF_RST_CTRL;
      nxt_st.fall_cfg = MIRF_RST_CFG;
      nxt_st.wake_dur = MIRF_RST_CFG;
    end
  end

  always_ff @(posedge i_mclk) begin
    st_ff <= nxt_st;
  end

  assign o_rdata = st_ff.rdata;
  assign o_irq_pin_a = st_ff.pin_a;
  assign o_irq_pin_b = st_ff.pin_b;

endmodule // mirf_router

// *** mirf_router_props.sv ***
// Checker for pin routing, merge, polarity and register read rules of the router
`timescale 1ns/1ps
module mirf_router_props
  import mirf_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [MIRF_AW-1:0] i_addr,
  input wire logic [MIRF_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [MIRF_DW-1:0] o_rdata,
  // Data events
  input wire logic i_stamp_drdy,
  input wire logic i_batch_count,
  input wire logic i_queue_full,
  input wire logic i_queue_overrun,
  input wire logic i_queue_level,
  input wire logic i_boot_done,
  input wire logic i_gyro_ready,
  input wire logic i_accel_ready,
  input wire logic i_temp_ready,
  // Pins
  input wire logic o_irq_pin_a,
  input wire logic o_irq_pin_b
);
  logic [7:0] sh_ff [5];
  logic [1:0] age_ff;
  logic [7:0] ev_a;
  logic [7:0] ev_b;
  logic quiet;
  assign ev_a = {i_stamp_drdy, i_batch_count, i_queue_full, i_queue_overrun, i_queue_level, i_boot_done,
                 i_gyro_ready, i_accel_ready};
  assign ev_b = {1'b0, i_batch_count, i_queue_full, i_queue_overrun, i_queue_level, i_temp_ready,
                 i_gyro_ready, i_accel_ready};
  // Judge pins only once the last write has settled through the registered pin
  assign quiet = (age_ff == 2'h3) && !sh_ff[4][2];
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      age_ff <= 2'h0;
      for (int k = 0; k < 5; k++) begin
        sh_ff[k] <= 8'h00;
      end
    end else begin
      if (i_wr) begin
        age_ff <= 2'h0;
      end else if (age_ff != 2'h3) begin
        age_ff <= age_ff + 2'h1;
      end
      if (i_wr && (i_addr < 4'h5)) begin
        sh_ff[i_addr[2:0]] <= i_wdata;
      end
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_pin_a_or: assert property (quiet && (sh_ff[1] == 8'h00) |->
    o_irq_pin_a == (sh_ff[4][3] ^ (|(sh_ff[0] & $past(ev_a))))) else $error("pin a not OR of routed events");
  a_pin_b_or: assert property (quiet && (sh_ff[3] == 8'h00) |->
    o_irq_pin_b == (sh_ff[4][3] ^ (|(sh_ff[2] & $past(ev_b))))) else $error("pin b not OR of routed events");
  a_merge_pin_b: assert property ((age_ff == 2'h3) && sh_ff[4][2] |->
    o_irq_pin_b == sh_ff[4][3]) else $error("pin b active while merged");
  a_reset_idle: assert property ($fell(i_rst) |-> !o_irq_pin_a && !o_irq_pin_b)
    else $error("pins not idle low after reset");
  a_motion_rsvd: assert property ($past(i_rd) && ($past(i_addr) == MIRF_OFS_P1_MOTION ||
    $past(i_addr) == MIRF_OFS_P2_MOTION) |-> o_rdata[6] == 1'b0 && o_rdata[3] == 1'b0) else $error("motion bit set");
  a_data_b_rsvd: assert property ($past(i_rd) && $past(i_addr) == MIRF_OFS_P2_DATA |-> !o_rdata[7])
    else $error("pin b data route b7 set");
  a_summary_rsvd: assert property ($past(i_rd) && $past(i_addr) == MIRF_OFS_SUMMARY |->
    o_rdata[7:4] == 4'h0) else $error("summary upper bits set");
  a_basic_off: assert property ($past(i_rd) && $past(i_addr) == MIRF_OFS_SUMMARY && (age_ff == 2'h3) &&
    !sh_ff[4][7] |-> o_rdata == 8'h00) else $error("motion flag while disabled");
endmodule // mirf_router_props

bind mirf_router mirf_router_props i_mirf_router_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_stamp_drdy(i_stamp_drdy),
  .i_batch_count(i_batch_count), .i_queue_full(i_queue_full), .i_queue_overrun(i_queue_overrun),
  .i_queue_level(i_queue_level), .i_boot_done(i_boot_done), .i_gyro_ready(i_gyro_ready),
  .i_accel_ready(i_accel_ready), .i_temp_ready(i_temp_ready), .o_irq_pin_a(o_irq_pin_a),
  .o_irq_pin_b(o_irq_pin_b));

// *** tb_motion_irq_router_freefall.sv ***
// Self-checking bench for the motion interrupt router with free-fall detector
`timescale 1ns/1ps
module tb_motion_irq_router_freefall;
  import mirf_pkg::*;
  logic clk, rst, wr, rd, stb, pin_a, pin_b;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [11:0] ev;
  logic [2:0] mev;
  logic act;
  logic signed [15:0] ax, ay, az;
  logic [7:0] msk [4] = '{8'hff, 8'hb7, 8'h7f, 8'hb7};
  int err_count, total_checks, i;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  mirf_host i_mirf_host (.i_mclk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  mirf_router i_mirf_router (.i_mclk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_stamp_drdy(ev[7]), .i_batch_count(ev[6]), .i_queue_full(ev[5]),
    .i_queue_overrun(ev[4]), .i_queue_level(ev[3]), .i_boot_done(ev[2]), .i_gyro_ready(ev[1]),
    .i_accel_ready(ev[0]), .i_temp_ready(ev[8]), .i_embedded(ev[9]), .i_hub_done(ev[10]),
    .i_stamp_overflow(ev[11]), .i_wake_evt(mev[0]), .i_orient_evt(mev[1]), .i_activity_evt(mev[2]),
    .i_orient_axes(ev[5:0]), .i_accel_active(act), .i_sample_stb(stb), .i_accel_x(ax), .i_accel_y(ay),
    .i_accel_z(az), .o_irq_pin_a(pin_a), .o_irq_pin_b(pin_b));
  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_mirf_host.rd_reg(a, v);
    chk(nm, exp, v);
  endtask
  task automatic pins(input string nm, input logic a, input logic b);
    wt(3);
    chk(nm, {6'h00, a, b}, {6'h00, pin_a, pin_b});
  endtask
  task automatic route(input logic [3:0] a, input int b, input logic [14:0] e, input logic on_b);
    i_mirf_host.wr_reg(a, 8'h01 << b);
    {mev, ev} <= e;
    pins("route on", !on_b, on_b);
    @(posedge clk);
    {mev, ev} <= 15'h0000;
    i_mirf_host.wr_reg(a, 8'h00);
    pins("route off", 1'b0, 1'b0);
  endtask
  task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
    @(posedge clk);
    ax <= x;
    ay <= y;
    az <= z;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    wt(3);
  endtask
  // Just inside the 312 mg zone on two axes
  task automatic inz(input int n);
    repeat (n) smp(16'sd311, -16'sd311, 16'sd0);
  endtask
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    ev = 12'h000;
    mev = 3'h0;
    act = 1'b1;
    stb = 1'b0;
    ax = 16'sh0000;
    ay = 16'sh0000;
    az = 16'sh0000;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    for (i = 0; i < 4; i++)
      rdchk("route reset", i[3:0], 8'h00);
    for (i = 0; i < 4; i++) begin
      i_mirf_host.wr_reg(i[3:0], 8'hff);
      rdchk("route mask", i[3:0], msk[i]);
      i_mirf_host.wr_reg(i[3:0], 8'h00);
    end
    i_mirf_host.wr_reg(4'hf, 8'h5a);
    rdchk("unmapped", 4'hf, 8'h00);
    for (i = 0; i < 8; i++)
      route(MIRF_OFS_P1_DATA, i, 15'h0001 << i, 1'b0);
    for (i = 0; i < 7; i++)
      route(MIRF_OFS_P2_DATA, i, (i == 2) ? 15'h0100 : 15'h0001 << i, 1'b1);
    route(MIRF_OFS_P1_MOTION, 1, 15'h0200, 1'b0);
    route(MIRF_OFS_P1_MOTION, 0, 15'h0400, 1'b0);
    route(MIRF_OFS_P2_MOTION, 1, 15'h0200, 1'b1);
    route(MIRF_OFS_P2_MOTION, 0, 15'h0800, 1'b1);
    i_mirf_host.wr_reg(MIRF_OFS_P2_DATA, 8'h01);
    ev <= 12'h001;
    pins("pin b alone", 1'b0, 1'b1);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h04);
    pins("merged", 1'b1, 1'b0);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h0c);
    pins("merged active low", 1'b0, 1'b1);
    @(posedge clk);
    ev <= 12'h000;
    pins("idle high", 1'b1, 1'b1);
    i_mirf_host.wr_reg(MIRF_OFS_P2_DATA, 8'h00);
    i_mirf_host.wr_reg(MIRF_OFS_FALL_CFG, 8'h13);
    i_mirf_host.wr_reg(MIRF_OFS_P1_MOTION, 8'h10);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h83);
    inz(1);
    pins("short fall", 1'b0, 1'b0);
    inz(1);
    pins("fall seen", 1'b1, 1'b0);
    smp(16'sd312, 16'sd0, 16'sd0);
    pins("fall held", 1'b1, 1'b0);
    rdchk("summary", MIRF_OFS_SUMMARY, 8'h01);
    pins("clear on read", 1'b0, 1'b0);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h81);
    inz(2);
    smp(16'sd312, 16'sd0, 16'sd0);
    rdchk("fall source", MIRF_OFS_WAKE_FALL_SRC, 8'h20);
    pins("clear waits", 1'b1, 1'b0);
    smp(16'sd312, 16'sd0, 16'sd0);
    pins("clear at sample", 1'b0, 1'b0);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h80);
    inz(1);
    smp(16'sd0, 16'sd400, 16'sd0);
    inz(1);
    pins("count restart", 1'b0, 1'b0);
    inz(1);
    pins("fall live", 1'b1, 1'b0);
    smp(16'sd0, 16'sd0, -16'sd312);
    pins("fall drops", 1'b0, 1'b0);
    i_mirf_host.wr_reg(MIRF_OFS_FALL_CFG, 8'h07);
    smp(16'sd499, -16'sd499, 16'sd499);
    pins("wide zone", 1'b1, 1'b0);
    smp(16'sd0, 16'sd500, 16'sd0);
    pins("wide zone edge", 1'b0, 1'b0);
    i_mirf_host.wr_reg(MIRF_OFS_FALL_CFG, 8'h13);
    i_mirf_host.wr_reg(MIRF_OFS_P1_MOTION, 8'h00);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h81);
    inz(2);
    smp(16'sd312, 16'sd0, 16'sd0);
    rdchk("unrouted", MIRF_OFS_WAKE_FALL_SRC, 8'h00);
    i_mirf_host.wr_reg(MIRF_OFS_P1_MOTION, 8'h10);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h01);
    inz(2);
    pins("disabled", 1'b0, 1'b0);
    rdchk("disabled summary", MIRF_OFS_SUMMARY, 8'h00);
    // Condition is still up from the disabled run, so a live detector would fire here
    @(posedge clk);
    act <= 1'b0;
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'h80);
    inz(2);
    pins("accel off", 1'b0, 1'b0);
    @(posedge clk);
    act <= 1'b1;
    route(MIRF_OFS_P1_MOTION, 5, 15'h1000, 1'b0);
    route(MIRF_OFS_P2_MOTION, 2, 15'h2000, 1'b1);
    route(MIRF_OFS_P1_MOTION, 7, 15'h4000, 1'b0);
    @(posedge clk);
    {mev, ev} <= 15'h2015;
    rdchk("orient summary", MIRF_OFS_SUMMARY, 8'h04);
    rdchk("orient source", MIRF_OFS_ORIENT_SRC, 8'h55);
    i_mirf_host.wr_reg(MIRF_OFS_CTRL, 8'hff);
    rdchk("ctrl mask", MIRF_OFS_CTRL, 8'h8f);
    rdchk("fall cfg", MIRF_OFS_FALL_CFG, 8'h13);
    i_mirf_host.wr_reg(MIRF_OFS_WAKE_DUR, 8'hff);
    rdchk("duration high bit", MIRF_OFS_WAKE_DUR, 8'h80);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    rdchk("reset again", MIRF_OFS_P1_MOTION, 8'h00);
    give_verdict();
  end
endmodule // tb_motion_irq_router_freefall
